/* File: usart_char_tx_rx_core.sv */
// Character transmit and receive core with an AXI4-Lite register slave.
`timescale 1ns/1ps
module usart_char_tx_rx_core (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial lines.
    input wire logic rxd,
    output logic txd
);
    import usart_pkg::*;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP,
        TX_GUARD} tx_st_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_st_t;
    // Receiver state, declared early since the enable logic reads it.
    rx_st_t rx_st_ff;

    mode_t mode_ff;
    logic [15:0] div_ff;
    logic [7:0] guard_ff;
    stat_t stat;
    logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] rresp_ff, bresp_ff;
    logic wr_go, rd_go;
    logic [31:0] cmd;
    logic rx_en_ff, tx_en_ff, rx_stop_req_ff, tx_stop_req_ff;
    logic [8:0] thr_ff, rhr_ff;
    logic thr_full_ff, thr_addr_ff, send_address_cmd_ff;
    logic rx_rdy_ff, ovr_ff, parity_error_flag_ff;
    logic [2:0] rxd_sync_ff;
    logic rx_lvl_ff;
    logic [15:0] div_cnt_ff;
    logic tick;
    logic [4:0] ovs, tx_ph_ff, rx_ph_ff;
    logic [3:0] nbits;
    logic par_on, mdrop;

    // AXI4-Lite handshake and write decode.
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_go = aw_ff && w_ff && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign cmd = (wr_go && awaddr_ff == CTRL_OFF) ? wdata_ff : 32'h0;

    // Write address and data capture in either order, then response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                case (awaddr_ff)
                    CTRL_OFF, MODE_OFF, THR_OFF, BRG_OFF, TTG_OFF:
                        bresp_ff <= 2'h0;
                    default: bresp_ff <= 2'h2;
                endcase
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers accept writes whether or not enabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= MODE_RST;
            div_ff <= DIV_RST;
            guard_ff <= GUARD_RST;
        end else if (wr_go) begin
            if (awaddr_ff == MODE_OFF) begin
                mode_ff <= wdata_ff;
                if (wdata_ff[13:12] == STOP_ONEHALF && wdata_ff[8]) begin
                    mode_ff.stop_count_field <= STOP_ONE;
                end
            end
            if (awaddr_ff == BRG_OFF) begin
                div_ff <= wdata_ff[15:0];
            end
            if (awaddr_ff == TTG_OFF) begin
                guard_ff <= wdata_ff[7:0];
            end
        end
    end

    assign stat.rx_ready_flag = rx_rdy_ff;
    assign stat.tx_ready_flag = tx_en_ff && !thr_full_ff;
    assign stat.overrun_flag = ovr_ff;
    assign stat.parity_error_flag = parity_error_flag_ff;

    // Read path; reading the receive holding register clears ready.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'h0;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= 2'h0;
            case (s_axi_araddr)
                MODE_OFF: rdata_ff <= mode_ff;
                BRG_OFF: rdata_ff <= {16'h0, div_ff};
                TTG_OFF: rdata_ff <= {24'h0, guard_ff};
                RHR_OFF: rdata_ff <= {23'h0, rhr_ff};
                STAT_OFF: begin
                    rdata_ff <= 32'h0;
                    rdata_ff[ST_RX_READY_FLAG_B] <= stat.rx_ready_flag;
                    rdata_ff[ST_TX_READY_FLAG_B] <= stat.tx_ready_flag;
                    rdata_ff[ST_OVR_B] <= stat.overrun_flag;
                    rdata_ff[ST_PAR_B] <= stat.parity_error_flag;
                    rdata_ff[ST_TX_EMPTY_FLAG_B] <= stat.tx_empty_flag;
                end
                CTRL_OFF, THR_OFF: rdata_ff <= 32'h0;
                default: begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= 2'h2;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Frame shape shared by both directions.
    assign ovs = mode_ff.over_sel ? OVS_8 : OVS_16;
    assign nbits = mode_ff.nine_bit_sel ? 4'h9 :
        4'h5 + {2'b00, mode_ff.char_length_field};
    assign mdrop = mode_ff.parity_type_field[2:1] == 2'b11;
    assign par_on = mode_ff.parity_type_field <= PAR_MARK || mdrop;

    // Sample tick: system clock divided by the divisor field.
    always_ff @(posedge aclk) begin
        if (!aresetn || div_cnt_ff + 16'h1 >= div_ff) begin
            div_cnt_ff <= 16'h0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h1;
        end
    end
    assign tick = div_ff != 16'h0 && div_cnt_ff + 16'h1 >= div_ff;

    // Parity of a character under the current mode.
    function automatic logic par_calc(input logic [8:0] d, input logic adr);
        logic x;
        x = ^(d & ((9'h1 << nbits) - 9'h1));
        case (mode_ff.parity_type_field)
            PAR_EVEN: par_calc = x;
            PAR_ODD: par_calc = ~x;
            PAR_SPACE: par_calc = 1'b0;
            PAR_MARK: par_calc = 1'b1;
            default: par_calc = adr;
        endcase
    endfunction : par_calc

    // Transmitter.
    tx_st_t tx_st_ff;
    logic [8:0] tsh_ff;
    logic tsh_par_ff;
    logic [3:0] tx_bit_ff;
    logic [7:0] tx_gcnt_ff;
    logic tx_bit_end, tx_load;
    assign tx_bit_end = tick && (tx_ph_ff == ovs - 5'h1 ||
        (mode_ff.sync_sel && 1'b1));
    assign tx_load = thr_full_ff && (tx_st_ff == TX_IDLE ||
        (tx_bit_end && ((tx_st_ff == TX_STOP && tx_bit_ff == 4'h0 &&
        guard_ff == 8'h0) || (tx_st_ff == TX_GUARD && tx_gcnt_ff == 8'h1))));
    assign stat.tx_empty_flag = tx_en_ff && !thr_full_ff &&
        tx_st_ff == TX_IDLE;

    // Enables, disables and soft resets of both directions.
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd[RX_SOFT_RESET_CMD_B]) begin
            rx_en_ff <= 1'b0;
            rx_stop_req_ff <= 1'b0;
        end else if (cmd[RX_DISABLE_CMD_B]) begin
            rx_stop_req_ff <= 1'b1;
        end else if (cmd[RX_ENABLE_CMD_B]) begin
            rx_en_ff <= 1'b1;
            rx_stop_req_ff <= 1'b0;
        end else if (rx_stop_req_ff && rx_st_ff == RX_IDLE) begin
            rx_en_ff <= 1'b0;
            rx_stop_req_ff <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd[TX_SOFT_RESET_CMD_B]) begin
            tx_en_ff <= 1'b0;
            tx_stop_req_ff <= 1'b0;
        end else if (cmd[TX_DISABLE_CMD_B]) begin
            tx_stop_req_ff <= 1'b1;
        end else if (cmd[TX_ENABLE_CMD_B]) begin
            tx_en_ff <= 1'b1;
            tx_stop_req_ff <= 1'b0;
        end else if (tx_stop_req_ff && !thr_full_ff &&
            tx_st_ff == TX_IDLE) begin
            tx_en_ff <= 1'b0;
            tx_stop_req_ff <= 1'b0;
        end
    end

    // Holding register and send-address marker.
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd[TX_SOFT_RESET_CMD_B]) begin
            thr_full_ff <= 1'b0;
            thr_ff <= 9'h0;
            thr_addr_ff <= 1'b0;
            send_address_cmd_ff <= 1'b0;
        end else begin
            if (cmd[SEND_ADDRESS_CMD_B]) begin
                send_address_cmd_ff <= 1'b1;
            end
            if (tx_load && tx_en_ff) begin
                thr_full_ff <= 1'b0;
            end else if (wr_go && awaddr_ff == THR_OFF && tx_en_ff &&
                !tx_stop_req_ff && !thr_full_ff) begin
                thr_ff <= wdata_ff[8:0];
                thr_full_ff <= 1'b1;
                thr_addr_ff <= send_address_cmd_ff;
                send_address_cmd_ff <= cmd[SEND_ADDRESS_CMD_B];
            end
        end
    end

    // Transmit sequencer; line falls at load, then changes at bit boundaries of the tick.
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd[TX_SOFT_RESET_CMD_B]) begin
            tx_st_ff <= TX_IDLE;
            txd <= 1'b1;
            tx_ph_ff <= 5'h0;
            tx_bit_ff <= 4'h0;
            tx_gcnt_ff <= 8'h0;
            tsh_ff <= 9'h0;
            tsh_par_ff <= 1'b0;
        end else if (tx_load && tx_en_ff) begin
            tx_st_ff <= TX_START;
            txd <= 1'b0;
            tx_ph_ff <= 5'h0;
            tsh_ff <= mode_ff.msb_first_sel ?
                9'(thr_ff << (4'h9 - nbits)) : thr_ff;
            tsh_par_ff <= par_calc(thr_ff, thr_addr_ff);
        end else if (tick) begin
            tx_ph_ff <= tx_bit_end ? 5'h0 : tx_ph_ff + 5'h1;
            if (tx_bit_end) begin
                case (tx_st_ff)
                    TX_START, TX_DATA: begin
                        if (tx_st_ff == TX_START) begin
                            tx_bit_ff <= nbits - 4'h1;
                        end else begin
                            tx_bit_ff <= tx_bit_ff - 4'h1;
                        end
                        if (tx_st_ff == TX_DATA && tx_bit_ff == 4'h0) begin
                            tx_st_ff <= par_on ? TX_PAR : TX_STOP;
                            txd <= par_on ? tsh_par_ff : 1'b1;
                            tx_bit_ff <= mode_ff.stop_count_field == STOP_TWO ?
                                4'h1 : 4'h0;
                        end else begin
                            tx_st_ff <= TX_DATA;
                            txd <= mode_ff.msb_first_sel ? tsh_ff[8] :
                                tsh_ff[0];
                            tsh_ff <= mode_ff.msb_first_sel ?
                                {tsh_ff[7:0], 1'b0} : {1'b0, tsh_ff[8:1]};
                        end
                    end
                    TX_PAR: begin
                        tx_st_ff <= TX_STOP;
                        txd <= 1'b1;
                    end
                    TX_STOP: begin
                        if (tx_bit_ff != 4'h0) begin
                            tx_bit_ff <= tx_bit_ff - 4'h1;
                        end else if (guard_ff != 8'h0) begin
                            tx_st_ff <= TX_GUARD;
                            tx_gcnt_ff <= guard_ff;
                        end else begin
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                    TX_GUARD: begin
                        if (tx_gcnt_ff == 8'h1) begin
                            tx_st_ff <= TX_IDLE;
                        end
                        tx_gcnt_ff <= tx_gcnt_ff - 8'h1;
                    end
                    default: tx_st_ff <= TX_IDLE;
                endcase
            end
        end
    end

    // Receive line synchroniser; the first stage feeds only the second.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_sync_ff <= 3'b111;
            rx_lvl_ff <= 1'b1;
        end else begin
            rxd_sync_ff <= {rxd_sync_ff[1:0], rxd};
            if (rxd_sync_ff[1] == rxd_sync_ff[2]) begin
                rx_lvl_ff <= rxd_sync_ff[2];
            end
        end
    end

    // Receiver sequencer.
    logic [8:0] rsh_ff;
    logic [3:0] rx_bit_ff;
    logic rx_samp;
    logic [8:0] rx_char;
    assign rx_samp = tick && (mode_ff.sync_sel || rx_ph_ff == ovs - 5'h1);
    assign rx_char = mode_ff.msb_first_sel ? rsh_ff :
        9'(rsh_ff >> (4'h9 - nbits));
    always_ff @(posedge aclk) begin
        if (!aresetn || cmd[RX_SOFT_RESET_CMD_B]) begin
            rx_st_ff <= RX_IDLE;
            rx_ph_ff <= 5'h0;
            rx_bit_ff <= 4'h0;
            rsh_ff <= 9'h0;
            rhr_ff <= 9'h0;
            rx_rdy_ff <= 1'b0;
            ovr_ff <= 1'b0;
            parity_error_flag_ff <= 1'b0;
        end else begin
            if (cmd[CLRST_B]) begin
                ovr_ff <= 1'b0;
                parity_error_flag_ff <= 1'b0;
            end
            if (rd_go && s_axi_araddr == RHR_OFF) begin
                rx_rdy_ff <= 1'b0;
            end
            if (tick) begin
                rx_ph_ff <= rx_samp ? 5'h0 : rx_ph_ff + 5'h1;
                case (rx_st_ff)
                    RX_IDLE: begin
                        rx_ph_ff <= 5'h0;
                        if (rx_en_ff && !rx_stop_req_ff && !rx_lvl_ff) begin
                            // Synchronous mode has no half-bit start hunt.
                            rx_st_ff <= mode_ff.sync_sel ? RX_DATA :
                                RX_START;
                            rx_bit_ff <= nbits - 4'h1;
                            rx_ph_ff <= 5'h1;
                        end
                    end
                    RX_START: begin
                        if (rx_lvl_ff) begin
                            rx_st_ff <= RX_IDLE;
                        end else if (rx_ph_ff == (ovs >> 1) - 5'h1) begin
                            rx_st_ff <= RX_DATA;
                            rx_ph_ff <= 5'h0;
                        end
                    end
                    RX_DATA: if (rx_samp) begin
                        rsh_ff <= mode_ff.msb_first_sel ?
                            {rsh_ff[7:0], rx_lvl_ff} :
                            {rx_lvl_ff, rsh_ff[8:1]};
                        rx_bit_ff <= rx_bit_ff - 4'h1;
                        if (rx_bit_ff == 4'h0) begin
                            rx_st_ff <= par_on ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: if (rx_samp) begin
                        rx_st_ff <= RX_STOP;
                        if (rx_lvl_ff != par_calc(rx_char, 1'b0)) begin
                            parity_error_flag_ff <= 1'b1;
                        end
                    end
                    RX_STOP: if (rx_samp) begin
                        rx_st_ff <= RX_IDLE;
                        rhr_ff <= rx_char;
                        rx_rdy_ff <= 1'b1;
                        if (rx_rdy_ff &&
                            !(rd_go && s_axi_araddr == RHR_OFF)) begin
                            ovr_ff <= 1'b1;
                        end
                    end
                    default: rx_st_ff <= RX_IDLE;
                endcase
            end
        end
    end

    // Checks on the observable behaviour.
    AST_TX_FLAGS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !tx_en_ff |-> !stat.tx_ready_flag && !stat.tx_empty_flag)
        else $error("tx flags high while disabled");
    AST_TX_IDLE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_st_ff == TX_IDLE |-> txd)
        else $error("tx line low while idle");
    AST_SOFT_RST_TX: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd[TX_SOFT_RESET_CMD_B] |=> tx_st_ff == TX_IDLE && !tx_en_ff && txd)
        else $error("tx soft reset did not abort");
    AST_SOFT_RST_RX: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd[RX_SOFT_RESET_CMD_B] |=> rx_st_ff == RX_IDLE && !rx_en_ff)
        else $error("rx soft reset did not abort");
    AST_OVR_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        ovr_ff && !cmd[CLRST_B] && !cmd[RX_SOFT_RESET_CMD_B] |=> ovr_ff)
        else $error("overrun cleared without command");
    AST_PARITY_ERROR_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        parity_error_flag_ff && !cmd[CLRST_B] && !cmd[RX_SOFT_RESET_CMD_B] |=> parity_error_flag_ff)
        else $error("parity error cleared without command");
    AST_START_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_st_ff == TX_START |-> !txd)
        else $error("start bit not low");
    AST_GUARD_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_st_ff == TX_GUARD |-> txd && !stat.tx_empty_flag)
        else $error("guard period not idle high");
    AST_RX_DIS_FINISH: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_en_ff && !cmd[RX_SOFT_RESET_CMD_B] && rx_st_ff != RX_IDLE |=> rx_en_ff)
        else $error("receiver stopped mid character");
    AST_THR_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        thr_full_ff && !tx_load && !cmd[TX_SOFT_RESET_CMD_B] |=> $stable(thr_ff))
        else $error("occupied holding register overwritten");
    COV_TX_GUARD: cover property (@(posedge aclk) tx_st_ff == TX_GUARD);
    COV_RX_DONE: cover property (@(posedge aclk) $rose(rx_rdy_ff));
    COV_OVR: cover property (@(posedge aclk) $rose(ovr_ff));
    COV_PARITY_ERROR_FLAG: cover property (@(posedge aclk) $rose(parity_error_flag_ff));
endmodule : usart_char_tx_rx_core

/* File: usart_pkg.sv */
// Package of constants, field layouts and carriers for the serial core.
package usart_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MODE_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h14;
    localparam logic [7:0] RHR_OFF = 8'h18;
    localparam logic [7:0] THR_OFF = 8'h1c;
    localparam logic [7:0] BRG_OFF = 8'h20;
    localparam logic [7:0] TTG_OFF = 8'h28;
    // Control command bit positions.
    localparam int RX_SOFT_RESET_CMD_B = 2;
    localparam int TX_SOFT_RESET_CMD_B = 3;
    localparam int RX_ENABLE_CMD_B = 4;
    localparam int RX_DISABLE_CMD_B = 5;
    localparam int TX_ENABLE_CMD_B = 6;
    localparam int TX_DISABLE_CMD_B = 7;
    localparam int CLRST_B = 8;
    localparam int SEND_ADDRESS_CMD_B = 12;
    // Status bit positions.
    localparam int ST_RX_READY_FLAG_B = 0;
    localparam int ST_TX_READY_FLAG_B = 1;
    localparam int ST_OVR_B = 5;
    localparam int ST_PAR_B = 7;
    localparam int ST_TX_EMPTY_FLAG_B = 9;
    // Parity codes of the parity type field, then stop count codes.
    localparam logic [2:0] PAR_EVEN = 3'h0;
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [1:0] STOP_ONE = 2'h0;
    localparam logic [1:0] STOP_ONEHALF = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;
    // Oversampling ratios.
    localparam logic [4:0] OVS_16 = 5'h10;
    localparam logic [4:0] OVS_8 = 5'h08;
    // Reset values.
    localparam logic [31:0] MODE_RST = 32'h0000_00c0;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [7:0] GUARD_RST = 8'h00;

    // Mode register fields in packed form.
    typedef struct packed {
        logic [11:0] rsv_hi;
        logic msb_first_sel;
        logic rsv_b18;
        logic nine_bit_sel;
        logic rsv_b16;
        logic over_sel;
        logic rsv_b14;
        logic [1:0] stop_count_field;
        logic [2:0] parity_type_field;
        logic sync_sel;
        logic [1:0] char_length_field;
        logic [5:0] rsv_lo;
    } mode_t;

    // Status flags carried as one group.
    typedef struct packed {
        logic rx_ready_flag;
        logic tx_ready_flag;
        logic overrun_flag;
        logic parity_error_flag;
        logic tx_empty_flag;
    } stat_t;
endpackage : usart_pkg

/* File: remote_serial_partner.sv */
// Remote serial device: frame catcher on txd and frame sender on rxd.
`timescale 1ns/1ps
module remote_serial_partner #(
    parameter int BIT_CYC = 16
) (
    // Clock and serial lines.
    input wire logic aclk,
    input wire logic txd,
    output logic rxd
);
    logic [9:0] got_q[$];
    logic [9:0] frame;
    // The line rests high between frames.
    initial rxd = 1'b1;
    // Sends start, eight data bits low first, parity, then one stop.
    task automatic send(input logic [7:0] d, input logic p);
        logic [10:0] f;
        f = {1'b1, p, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge aclk);
        end
    endtask : send
    // Samples each txd frame mid-bit and keeps data, parity and stop.
    always begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYC) @(posedge aclk);
            frame[i] = txd;
        end
        got_q.push_back(frame);
    end
endmodule : remote_serial_partner

/* File: testbench.sv */
// Self-checking bench for the serial core with a remote partner model.
`timescale 1ns/1ps
module testbench;
    import usart_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, rxd, txd;
    logic [7:0] s_axi_awaddr, s_axi_araddr, d;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, bs_q, rs_q;
    int fail_count, cmp_count;
    usart_char_tx_rx_core i_usart_char_tx_rx_core (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rxd, .txd);
    remote_serial_partner #(.BIT_CYC(16)) i_remote_serial_partner (.aclk,
        .txd, .rxd);
    // Expected parity for even, odd, space and mark.
    function automatic logic par_of(input int p, input logic [7:0] v);
        return (p == 0) ? ^v : (p == 1) ? ~^v : (p == 3);
    endfunction : par_of
    // Bit-reverses a byte, for frames sent most significant bit first.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7 - i];
        end
    endfunction : rev8
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Register write; each channel is released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (s_axi_awready) aw_p = 1'b0;
            if (s_axi_wready) w_p = 1'b0;
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        bs_q = s_axi_bresp;
    endtask : wr
    // Register read; the answer lands in rd_q.
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd_q = s_axi_rdata;
        rs_q = s_axi_rresp;
    endtask : rd
    // Prints the verdict and ends the run.
    task automatic summarize;
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Free-running 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        summarize;
    end
    // Main sequence: reset, transmit with even, odd, space and mark parity, then receive.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        void'($urandom(32'h637d));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(STAT_OFF);
        chk(rd_q, 32'h0);
        wr(MODE_OFF, MODE_RST | 32'h1100);
        chk({30'h0, bs_q}, 32'h0);
        rd(MODE_OFF);
        chk(rd_q, MODE_RST | 32'h100);
        chk({30'h0, rs_q}, 32'h0);
        wr(BRG_OFF, 32'h1);
        wr(CTRL_OFF, 32'h50);
        rd(STAT_OFF);
        chk(rd_q, 32'h202);
        for (int p = 0; p < 4; p++) begin
            d = (p < 2) ? 8'h41 : 8'($urandom);
            wr(MODE_OFF, MODE_RST | (32'(p) << 9));
            wr(THR_OFF, {24'h0, d});
            for (int n = 0; n < 400 &&
                i_remote_serial_partner.got_q.size() == 0; n++)
                @(posedge aclk);
            chk(32'(i_remote_serial_partner.got_q.pop_front()),
                {22'h0, 1'b1, par_of(p, d), d});
        end
        // Multidrop, MSB first, two guard bits, disable with traffic queued.
        repeat (40) @(posedge aclk);
        wr(MODE_OFF, MODE_RST | 32'h8_0c00);
        wr(TTG_OFF, 32'h2);
        wr(CTRL_OFF, 32'h1000);
        wr(THR_OFF, {24'h0, d});
        wr(THR_OFF, {24'h0, ~d});
        wr(THR_OFF, 32'h0);
        wr(CTRL_OFF, 32'h80);
        rd(STAT_OFF);
        chk(rd_q, 32'h0);
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 400 &&
                i_remote_serial_partner.got_q.size() == 0; n++)
                @(posedge aclk);
            chk(32'(i_remote_serial_partner.got_q.pop_front()),
                {22'h0, 1'b1, k == 0, rev8(k ? ~d : d)});
        end
        repeat (20) @(posedge aclk);
        rd(STAT_OFF);
        chk(rd_q, 32'h2);
        repeat (30) @(posedge aclk);
        rd(STAT_OFF);
        chk(rd_q, 32'h0);
        chk(32'(i_remote_serial_partner.got_q.size()), 32'h0);
        wr(CTRL_OFF, 32'h40);
        wr(MODE_OFF, MODE_RST);
        d = 8'($urandom);
        i_remote_serial_partner.send(d, ^d);
        rd(STAT_OFF);
        chk(rd_q, 32'h203);
        i_remote_serial_partner.send(~d, ~^d);
        rd(STAT_OFF);
        chk(rd_q, 32'h2a3);
        rd(RHR_OFF);
        chk(rd_q, {24'h0, ~d});
        wr(CTRL_OFF, 32'h100);
        rd(STAT_OFF);
        chk(rd_q, 32'h202);
        wr(CTRL_OFF, 32'h8);
        rd(STAT_OFF);
        chk(rd_q, 32'h0);
        summarize;
    end
endmodule : testbench
